// ===== design/stg_pkg.sv
// Constants, field layout and types of the slot timing generator
package stg_pkg;
    // Timing
    localparam int unsigned STG_CLK_HZ          = 40_000_000;
    localparam int unsigned STG_REF_HZ          = 1000;
    localparam int unsigned STG_REF_HALF_CYCLES = STG_CLK_HZ / (2 * STG_REF_HZ);
    localparam int unsigned STG_DIV_W           = 16;
    // Decade counter
    localparam int unsigned STG_CNT_W           = 4;
    localparam int unsigned STG_TAPS            = 10;
    localparam logic [3:0]  STG_CNT_LAST        = 4'h9;
    localparam logic [3:0]  STG_CARRY_HIGH_LAST = 4'h4;
    localparam logic [3:0]  STG_TAP_WIN_A       = 4'h0;
    localparam logic [3:0]  STG_TAP_WIN_B       = 4'h5;
    // Register offsets
    localparam logic [7:0]  STG_OFS_CTRL        = 8'h00;
    localparam logic [7:0]  STG_OFS_STATUS      = 8'h04;
    localparam logic [7:0]  STG_OFS_ANTENNA     = 8'h08;
    localparam logic [7:0]  STG_OFS_LAMP_LOW    = 8'h0c;
    localparam logic [7:0]  STG_OFS_LAMP_HIGH   = 8'h10;
    localparam logic [7:0]  STG_OFS_INTEG       = 8'h14;
    // Control fields
    localparam int unsigned STG_CTRL_REF_EN     = 0;
    localparam int unsigned STG_CTRL_CNT_RST    = 1;
    localparam int unsigned STG_CTRL_GATE_A     = 2;
    localparam int unsigned STG_CTRL_GATE_B     = 4;
    localparam logic [5:0]  STG_CTRL_RESET      = 6'h02;
    // Status fields
    localparam int unsigned STG_ST_REF          = 0;
    localparam int unsigned STG_ST_CNT_RST      = 1;
    localparam int unsigned STG_ST_WIN_A        = 2;
    localparam int unsigned STG_ST_WIN_B        = 3;
    localparam int unsigned STG_ST_DRIVE        = 7;
    localparam int unsigned STG_ST_CARRIER      = 8;
    localparam int unsigned STG_ST_INTEG_A      = 9;
    localparam int unsigned STG_ST_INTEG_B      = 10;
    localparam int unsigned STG_ST_COUNT        = 12;
    // Lamp and integrator fields
    localparam int unsigned STG_LAMP_NINTH_BIT  = 4;
    localparam int unsigned STG_INT_DATA        = 0;
    localparam int unsigned STG_INT_DIR         = 1;
    localparam int unsigned STG_INT_OD          = 2;
    localparam int unsigned STG_INT_B_BASE      = 4;
    localparam logic [7:0]  STG_INTEG_RESET     = 8'h00;
    // AHB
    localparam logic [1:0]  STG_HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  STG_HTRANS_SEQ      = 2'h3;

    typedef enum logic [1:0] {
        STG_GATE_NONE   = 2'b00,
        STG_GATE_FIRST  = 2'b01,
        STG_GATE_SECOND = 2'b11
    } stg_gate_t;
endpackage : stg_pkg

// ===== design/stg_decade_counter.sv
// Ten-state decade counter with decoded taps and square-wave carry
`timescale 1ns/1ps
`default_nettype none
module stg_decade_counter
    import stg_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    // Control
    input  wire logic                 step_i,
    input  wire logic                 clear_i,
    // State
    output logic [STG_CNT_W-1:0]      count_o,
    output logic [STG_TAPS-1:0]       taps_o,
    output logic                      carry_o
);
    logic [STG_CNT_W-1:0] count_reg;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            count_reg <= '0;
        else if (clear_i)
            count_reg <= '0;
        else if (step_i)
            count_reg <= (count_reg == STG_CNT_LAST) ? '0 : count_reg + 4'h1;
    end

    assign count_o = count_reg;
    assign taps_o  = STG_TAPS'(1) << count_reg;
    // Five states high, five low: even duty
    assign carry_o = (count_reg <= STG_CARRY_HIGH_LAST);
endmodule : stg_decade_counter
`default_nettype wire

// ===== design/stg_window_gate.sv
// Optional half-cycle gating of one sample window
`timescale 1ns/1ps
`default_nettype none
module stg_window_gate
    import stg_pkg::*;
(
    // Inputs
    input  wire logic       tap_i,
    input  wire logic       ref_i,
    input  wire logic [1:0] mode_i,
    // Output
    output logic            window_o
);
    always_comb
    begin
        case (mode_i)
            STG_GATE_FIRST:  window_o = tap_i & ref_i;
            STG_GATE_SECOND: window_o = tap_i & ~ref_i;
            // Unused code falls back to the full window
            default:         window_o = tap_i;
        endcase
    end
endmodule : stg_window_gate
`default_nettype wire

// ===== design/stg_top.sv
// Slot timing generator with AHB-Lite register access
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module stg_top
    import stg_pkg::*;
#(
    parameter int unsigned REF_HALF_CYCLES = STG_REF_HALF_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Slot timing
    output logic             ref_clock_o,
    output logic             counter_reset_o,
    output logic             sample_window_a_o,
    output logic             sample_window_b_o,
    // Antenna interface
    output logic             antenna_drive_o,
    output logic      [2:0]  antenna_index_o,
    // Radio status
    input  wire logic        carrier_detect_i,
    // Integrator clear pins
    input  wire logic        integrator_a_node_i,
    output logic             integrator_a_node_o,
    output logic             integrator_a_node_oe_o,
    input  wire logic        integrator_b_node_i,
    output logic             integrator_b_node_o,
    output logic             integrator_b_node_oe_o,
    // Display lamps
    output logic      [7:0]  display_lamp_first_o,
    output logic             display_lamp_ninth_o
);
    function automatic logic stg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        stg_hit = (addr == ofs);
    endfunction : stg_hit

    // Pin drive of one integrator node from its data, direction and mode bits
    function automatic logic [1:0] stg_pin(input logic [2:0] f);
        logic drv;
        logic oe;
        drv = 1'b0;
        oe  = 1'b0;
        if (f[STG_INT_OD])
        begin
            drv = 1'b0;
            oe  = ~f[STG_INT_DATA];
        end
        else
        begin
            drv = f[STG_INT_DATA];
            oe  = f[STG_INT_DIR];
        end
        stg_pin = {oe, drv};
    endfunction : stg_pin

    localparam logic [STG_DIV_W-1:0] DIV_LAST = STG_DIV_W'(REF_HALF_CYCLES - 1);

    // Registers
    logic [5:0]            ctrl_reg;
    logic [2:0]            antenna_reg;
    logic [7:0]            lamp_low_reg;
    logic                  lamp_ninth_reg;
    logic [7:0]            integ_reg;
    // Bus pipeline
    logic                  wr_pend_reg;
    logic [7:0]            wr_addr_reg;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;
    logic                  hready_reg;
    // Reference divider
    logic [STG_DIV_W-1:0]  div_reg;
    logic                  ref_reg;
    logic                  step;
    // Counter view
    logic [STG_CNT_W-1:0]  count;
    logic [STG_TAPS-1:0]   taps;
    logic                  carry;
    logic                  win_a;
    logic                  win_b;
    // Pin stage
    logic                  ref_out_reg;
    logic                  cnt_rst_out_reg;
    logic                  win_a_reg;
    logic                  win_b_reg;
    logic                  drive_reg;
    logic [2:0]            index_out_reg;
    logic [7:0]            lamp_out_reg;
    logic                  lamp9_out_reg;
    logic [1:0]            pin_a_reg;
    logic [1:0]            pin_b_reg;
    logic [31:0]           status;

    logic                  addr_valid;
    logic                  ref_en;
    logic                  cnt_rst;

    assign addr_valid = hsel_i && hready_i
                        && (htrans_i == STG_HTRANS_NONSEQ || htrans_i == STG_HTRANS_SEQ);
    assign ref_en     = ctrl_reg[STG_CTRL_REF_EN];
    assign cnt_rst    = ctrl_reg[STG_CTRL_CNT_RST];

    // Write data arrives one cycle after the address phase
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wr_pend_reg <= 1'b0;
        else
            wr_pend_reg <= addr_valid && hwrite_i;
    end

    // Address held for the data phase; only used with the pending flag
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wr_addr_reg <= 8'h00;
        else
            wr_addr_reg <= haddr_i[7:0];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ctrl_reg <= STG_CTRL_RESET;
        else if (wr_pend_reg && stg_hit(wr_addr_reg, STG_OFS_CTRL))
            ctrl_reg <= hwdata_i[5:0];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            antenna_reg <= 3'h0;
        else if (wr_pend_reg && stg_hit(wr_addr_reg, STG_OFS_ANTENNA))
            antenna_reg <= hwdata_i[2:0];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            lamp_low_reg <= 8'h00;
        else if (wr_pend_reg && stg_hit(wr_addr_reg, STG_OFS_LAMP_LOW))
            lamp_low_reg <= hwdata_i[7:0];
    end

    // Ninth lamp sits alone at bit 4 of its own word
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            lamp_ninth_reg <= 1'b0;
        else if (wr_pend_reg && stg_hit(wr_addr_reg, STG_OFS_LAMP_HIGH))
            lamp_ninth_reg <= hwdata_i[STG_LAMP_NINTH_BIT];
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            integ_reg <= STG_INTEG_RESET;
        else if (wr_pend_reg && stg_hit(wr_addr_reg, STG_OFS_INTEG))
            integ_reg <= hwdata_i[7:0];
    end

    // Reference clock divider; stops low while disabled
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            div_reg <= '0;
            ref_reg <= 1'b0;
        end
        else if (!ref_en)
        begin
            div_reg <= '0;
            ref_reg <= 1'b0;
        end
        else if (div_reg == DIV_LAST)
        begin
            div_reg <= '0;
            ref_reg <= ~ref_reg;
        end
        else
            div_reg <= div_reg + STG_DIV_W'(1);
    end

    // Rising edge of the reference steps the counter
    assign step = ref_en && (div_reg == DIV_LAST) && !ref_reg;

    stg_decade_counter u_counter (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .step_i    (step),
        .clear_i   (cnt_rst),
        .count_o   (count),
        .taps_o    (taps),
        .carry_o   (carry)
    );

    stg_window_gate u_gate_a (
        .tap_i    (taps[STG_TAP_WIN_A]),
        .ref_i    (ref_reg),
        .mode_i   (ctrl_reg[STG_CTRL_GATE_A +: 2]),
        .window_o (win_a)
    );

    stg_window_gate u_gate_b (
        .tap_i    (taps[STG_TAP_WIN_B]),
        .ref_i    (ref_reg),
        .mode_i   (ctrl_reg[STG_CTRL_GATE_B +: 2]),
        .window_o (win_b)
    );

    // One common output stage keeps all timing pins aligned
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ref_out_reg     <= 1'b0;
            cnt_rst_out_reg <= 1'b1;
            win_a_reg       <= 1'b0;
            win_b_reg       <= 1'b0;
            drive_reg       <= 1'b0;
        end
        else
        begin
            ref_out_reg     <= ref_reg;
            cnt_rst_out_reg <= cnt_rst;
            win_a_reg       <= win_a;
            win_b_reg       <= win_b;
            drive_reg       <= carry;
        end
    end

    // Index lines follow the register one edge later
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            index_out_reg <= 3'h0;
        else
            index_out_reg <= antenna_reg;
    end

    // Lamp pins
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lamp_out_reg  <= 8'h00;
            lamp9_out_reg <= 1'b0;
        end
        else
        begin
            lamp_out_reg  <= lamp_low_reg;
            lamp9_out_reg <= lamp_ninth_reg;
        end
    end

    // Clear pin drive; enable high while the node is driven
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_a_reg <= 2'h0;
            pin_b_reg <= 2'h0;
        end
        else
        begin
            pin_a_reg <= stg_pin(integ_reg[2:0]);
            pin_b_reg <= stg_pin(integ_reg[STG_INT_B_BASE +: 3]);
        end
    end

    // Status reflects the pins as driven; only the count field is read straight from the internal counter
    always_comb
    begin
        status                             = 32'h0000_0000;
        status[STG_ST_REF]                 = ref_out_reg;
        status[STG_ST_CNT_RST]             = cnt_rst_out_reg;
        status[STG_ST_WIN_A]               = win_a_reg;
        status[STG_ST_WIN_B]               = win_b_reg;
        status[STG_ST_DRIVE]               = drive_reg;
        status[STG_ST_CARRIER]             = carrier_detect_i;
        status[STG_ST_INTEG_A]             = integrator_a_node_i;
        status[STG_ST_INTEG_B]             = integrator_b_node_i;
        status[STG_ST_COUNT +: STG_CNT_W]  = count;
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (stg_hit(haddr_i[7:0], STG_OFS_CTRL))
            rdata_next = {26'h0, ctrl_reg};
        else if (stg_hit(haddr_i[7:0], STG_OFS_STATUS))
            rdata_next = status;
        else if (stg_hit(haddr_i[7:0], STG_OFS_ANTENNA))
            rdata_next = {29'h0, antenna_reg};
        else if (stg_hit(haddr_i[7:0], STG_OFS_LAMP_LOW))
            rdata_next = {24'h0, lamp_low_reg};
        else if (stg_hit(haddr_i[7:0], STG_OFS_LAMP_HIGH))
            rdata_next = {27'h0, lamp_ninth_reg, 4'h0};
        else if (stg_hit(haddr_i[7:0], STG_OFS_INTEG))
            rdata_next = {24'h0, integ_reg};
    end

    // Ready from the first edge after reset; never a wait state
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hready_reg <= 1'b0;
        else
            hready_reg <= 1'b1;
    end

    // Read data captured at the address phase, so no wait states
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_reg <= 32'h0000_0000;
        else if (addr_valid && !hwrite_i)
            rdata_reg <= rdata_next;
    end

    assign hrdata_o               = rdata_reg;
    assign hreadyout_o            = hready_reg;
    assign hresp_o                = 1'b0;
    assign ref_clock_o            = ref_out_reg;
    assign counter_reset_o        = cnt_rst_out_reg;
    assign sample_window_a_o      = win_a_reg;
    assign sample_window_b_o      = win_b_reg;
    assign antenna_drive_o        = drive_reg;
    assign antenna_index_o        = index_out_reg;
    assign integrator_a_node_o    = pin_a_reg[0];
    assign integrator_a_node_oe_o = pin_a_reg[1];
    assign integrator_b_node_o    = pin_b_reg[0];
    assign integrator_b_node_oe_o = pin_b_reg[1];
    assign display_lamp_first_o   = lamp_out_reg;
    assign display_lamp_ninth_o   = lamp9_out_reg;
endmodule : stg_top
`default_nettype wire

// ===== tb/stg_far_side.sv
// Model of the radio carrier line and the integrator nodes on the clear pins
`timescale 1ns/1ps
`default_nettype none
module stg_far_side (
    // Stimulus from the bench
    input  wire logic carrier_req_i,
    input  wire logic hold_a_i,
    input  wire logic hold_b_i,
    // Clear pin drive from the device
    input  wire logic node_a_drv_i,
    input  wire logic node_a_oe_i,
    input  wire logic node_b_drv_i,
    input  wire logic node_b_oe_i,
    // Levels seen by the device
    output logic      carrier_detect_o,
    output logic      node_a_o,
    output logic      node_b_o
);
    assign carrier_detect_o = carrier_req_i;
    // Released node shows the capacitor charge, never the last drive
    assign node_a_o = node_a_oe_i ? node_a_drv_i : hold_a_i;
    assign node_b_o = node_b_oe_i ? node_b_drv_i : hold_b_i;
endmodule : stg_far_side
`default_nettype wire

// ===== tb/stg_chk.sv
// Port-level assertions for the slot timing generator
`timescale 1ns/1ps
`default_nettype none
module stg_chk
    import stg_pkg::*;
#(
    parameter int unsigned REF_HALF_CYCLES = 4
)
(
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        ref_clock_o,
    input wire logic        counter_reset_o,
    input wire logic        sample_window_a_o,
    input wire logic        sample_window_b_o,
    input wire logic        antenna_drive_o,
    input wire logic [2:0]  antenna_index_o,
    input wire logic [7:0]  display_lamp_first_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Wide counters so the full-rate divider also fits
    int unsigned ref_hi;
    int unsigned drv_lo;
    logic        wr_ph;
    assign wr_ph = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
        if (!resetn_i)
            ref_hi <= 0;
        else
            ref_hi <= ref_clock_o ? ref_hi + 1 : 0;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
        if (!resetn_i)
            drv_lo <= 0;
        else
            drv_lo <= antenna_drive_o ? 0 : drv_lo + 1;

    ref_half_a: assert property ($fell(ref_clock_o) |-> ref_hi == REF_HALF_CYCLES)
        else $error("reference high phase has wrong length");
    drive_duty_a: assert property ($rose(antenna_drive_o) && !counter_reset_o
        && !$past(counter_reset_o) |-> drv_lo == 10 * REF_HALF_CYCLES)
        else $error("antenna drive low phase has wrong length");
    carry_step_a: assert property ($fell(antenna_drive_o) |-> $rose(ref_clock_o))
        else $error("antenna drive fell without a reference rise");
    win_excl_a: assert property (!(sample_window_a_o && sample_window_b_o))
        else $error("both sample windows active");
    win_a_drive_a: assert property (sample_window_a_o |-> antenna_drive_o)
        else $error("window a outside the high drive half");
    win_b_drive_a: assert property (sample_window_b_o |-> !antenna_drive_o)
        else $error("window b outside the low drive half");
    hold_zero_a: assert property (counter_reset_o [*3] |->
        antenna_drive_o && !sample_window_b_o)
        else $error("counter not held at zero");
    bus_ready_a: assert property ($past(resetn_i) |-> hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    index_wr_a: assert property (wr_ph && haddr_i[7:0] == STG_OFS_ANTENNA |=>
        ##2 antenna_index_o == $past(hwdata_i[2:0], 2))
        else $error("antenna index not taken from write");
    lamp_wr_a: assert property (wr_ph && haddr_i[7:0] == STG_OFS_LAMP_LOW |=>
        ##2 display_lamp_first_o == $past(hwdata_i[7:0], 2))
        else $error("lamp bits not taken from write");

    cover property ($rose(sample_window_b_o));
    cover property ($fell(antenna_drive_o));
    cover property (hsel_i && htrans_i[1] && !hwrite_i);
endmodule : stg_chk

bind stg_top stg_chk #(.REF_HALF_CYCLES(REF_HALF_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ref_clock_o(ref_clock_o),
    .counter_reset_o(counter_reset_o), .sample_window_a_o(sample_window_a_o),
    .sample_window_b_o(sample_window_b_o), .antenna_drive_o(antenna_drive_o),
    .antenna_index_o(antenna_index_o), .display_lamp_first_o(display_lamp_first_o));
`default_nettype wire

// ===== tb/slot_timing_generator_tb.sv
// Self-checking bench for the slot timing generator
`timescale 1ns/1ps
`default_nettype none
module slot_timing_generator_tb;
    import stg_pkg::*;
    localparam int unsigned H = 4;
    logic        clk_sys_i, resetn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, seed, r, v;
    logic [1:0]  htrans_i, pa, pb;
    logic [2:0]  hsize_i, antenna_index_o;
    logic        ref_clock_o, counter_reset_o, sample_window_a_o, sample_window_b_o;
    logic        antenna_drive_o, carrier_detect_i, car_req, hold_a, hold_b, g;
    logic        integrator_a_node_i, integrator_a_node_o, integrator_a_node_oe_o;
    logic        integrator_b_node_i, integrator_b_node_o, integrator_b_node_oe_o;
    logic [7:0]  display_lamp_first_o;
    logic        display_lamp_ninth_o, rd_ph, chk_en;
    logic [31:0] exp_q[$];
    int          fail_count, checks, cnt, gm;

    stg_top #(.REF_HALF_CYCLES(H)) u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
        .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .ref_clock_o(ref_clock_o), .counter_reset_o(counter_reset_o),
        .sample_window_a_o(sample_window_a_o), .sample_window_b_o(sample_window_b_o),
        .antenna_drive_o(antenna_drive_o), .antenna_index_o(antenna_index_o),
        .carrier_detect_i(carrier_detect_i), .integrator_a_node_i(integrator_a_node_i),
        .integrator_a_node_o(integrator_a_node_o),
        .integrator_a_node_oe_o(integrator_a_node_oe_o),
        .integrator_b_node_i(integrator_b_node_i), .integrator_b_node_o(integrator_b_node_o),
        .integrator_b_node_oe_o(integrator_b_node_oe_o),
        .display_lamp_first_o(display_lamp_first_o),
        .display_lamp_ninth_o(display_lamp_ninth_o));
    stg_far_side u_far (
        .carrier_req_i(car_req), .hold_a_i(hold_a), .hold_b_i(hold_b),
        .node_a_drv_i(integrator_a_node_o), .node_a_oe_i(integrator_a_node_oe_o),
        .node_b_drv_i(integrator_b_node_o), .node_b_oe_i(integrator_b_node_oe_o),
        .carrier_detect_o(carrier_detect_i), .node_a_o(integrator_a_node_i),
        .node_b_o(integrator_b_node_i));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // Entered just after a rising edge; waits on the slave, never on a fixed count
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= STG_HTRANS_NONSEQ;
        haddr_i <= a;
        hwrite_i <= wr;
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
        htrans_i <= 2'h0;
        hwdata_i <= wr ? d : $random(seed);
        @(posedge clk_sys_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    endtask : xfer

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    // Clear pin as {drive, enable} for one node code
    function automatic logic [1:0] pin(input logic [2:0] c);
        return c[2] ? {1'b0, !c[0]} : {c[0], c[1]};
    endfunction : pin

    always @(posedge clk_sys_i)
    begin
        if (rd_ph && hreadyout_o === 1'b1)
            check("hrdata", hrdata_o, exp_q.pop_front());
        if (hreadyout_o === 1'b1)
            rd_ph <= hsel_i && htrans_i[1] && !hwrite_i;
    end

    // Tracks the decade count from the reference pin and checks taps at each half
    initial forever
    begin
        @(ref_clock_o);
        #1;
        if (ref_clock_o === 1'b1)
            cnt = (cnt + 1) % 10;
        g = (gm == 1) ? ref_clock_o : (gm == 3) ? !ref_clock_o : 1'b1;
        if (chk_en)
        begin
            check("window_a", sample_window_a_o, (cnt == 0) && g);
            check("window_b", sample_window_b_o, (cnt == 5) && g);
            check("drive", antenna_drive_o, cnt < 5);
        end
    end

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        #(25 * 20000);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        seed = 32'h96cc;
        {hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i, rd_ph, chk_en} = '0;
        {car_req, hold_a, hold_b, cnt, gm, fail_count, checks} = '0;
        hsize_i = 3'h2;
        resetn_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rd(STG_OFS_CTRL, 32'h2);
        rd(STG_OFS_INTEG, 32'h0);
        xfer(1'b1, 32'h18, 32'hffff_ffff);
        xfer(1'b1, STG_OFS_STATUS, 32'hffff_ffff);
        rd(32'h18, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            car_req <= r[8];
            hold_a <= r[9];
            hold_b <= r[10];
            v = (32'(7 - i) << 4) | 32'(i);
            xfer(1'b1, STG_OFS_INTEG, v);
            repeat (4) @(posedge clk_sys_i);
            pa = pin(v[2:0]);
            pb = pin(v[6:4]);
            check("node_a", {integrator_a_node_o, integrator_a_node_oe_o}, pa);
            check("node_b", {integrator_b_node_o, integrator_b_node_oe_o}, pb);
            rd(STG_OFS_INTEG, v);
            rd(STG_OFS_STATUS, {21'h0, pb[0] ? pb[1] : r[10], pa[0] ? pa[1] : r[9],
                r[8], 8'h86});
        end
        repeat (4)
        begin
            r = $random(seed);
            xfer(1'b1, STG_OFS_LAMP_LOW, r);
            xfer(1'b1, STG_OFS_LAMP_HIGH, ~r);
            xfer(1'b1, STG_OFS_ANTENNA, r >> 8);
            repeat (3) @(posedge clk_sys_i);
            check("lamp_low", display_lamp_first_o, r[7:0]);
            check("lamp_ninth", display_lamp_ninth_o, !r[4]);
            check("index", antenna_index_o, r[10:8]);
            rd(STG_OFS_LAMP_HIGH, ~r & 32'h10);
            rd(STG_OFS_ANTENNA, (r >> 8) & 32'h7);
        end
        for (int m = 0; m < 4; m++)
        begin
            chk_en = 1'b0;
            xfer(1'b1, STG_OFS_CTRL, 32'(m * 20 + 1));
            repeat (3) @(posedge clk_sys_i);
            gm = m;
            chk_en = 1'b1;
            @(negedge antenna_drive_o);
            @(posedge clk_sys_i);
            xfer(1'b1, STG_OFS_ANTENNA, 32'(m));
            repeat (100) @(posedge clk_sys_i);
        end
        chk_en = 1'b0;
        xfer(1'b1, STG_OFS_CTRL, 32'h3);
        repeat (4) @(posedge clk_sys_i);
        check("held_drive", antenna_drive_o, 1'b1);
        check("held_window_a", sample_window_a_o, 1'b1);
        check("held_window_b", sample_window_b_o, 1'b0);
        rd(STG_OFS_CTRL, 32'h3);
        repeat (2) @(posedge clk_sys_i);
        tally_and_finish();
    end
endmodule : slot_timing_generator_tb
`default_nettype wire
